// file: ssadc_top.sv
// serial control and successive-approximation sequencer of the converter
`timescale 1ns/1ns
`include "ssadc_defs.svh"

module ssadc_top
    import ssadc_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter bit HAS_SHIFT_ENABLE = 1'b1
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host serial pins
    input wire logic csN,
    input wire logic serialClk,
    input wire logic serialIn,
    input wire logic lsbFirstShiftEnableN,
    output logic serialOut,
    output logic serialOutOe,
    output logic conversionActive,
    // analog front end
    input wire logic compGreater,
    output logic [`SSADC_RES_BITS-1:0] trialCode,
    output logic [CHANNELS-1:0] posChannelSel,
    output logic [CHANNELS-1:0] negChannelSel,
    output logic negCommonSel,
    output logic singleEndedSelect,
    output logic samplePosStrobe,
    output logic sampleNegStrobe,
    output logic compStrobe,
    // result stream
    output logic [`SSADC_RES_BITS-1:0] resultData,
    output logic resultValid,
    input wire logic resultReady
);

    ////////////////////////////////////////////////////////////////////////////////
    // variant constants

    localparam int ADDR_BITS = (CHANNELS == 1) ? 0 : $clog2(CHANNELS) + 1;
    localparam int SEL_BITS = (ADDR_BITS > 2) ? ADDR_BITS - 2 : 0;
    localparam bit LSB_COPY = (CHANNELS > 1);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    ssadc_core_type coreQ;
    ssadc_core_type coreD;
    logic sclkRise;
    logic sclkFall;
    logic bufReady;
    logic lsbStep;

    ssadc_stream_if #(.WIDTH(`SSADC_RES_BITS)) resIf ();

    assign sclkRise = serialClk && !coreQ.sclkPrev;
    assign sclkFall = !serialClk && coreQ.sclkPrev;
    assign bufReady = resIf.ready;
    assign lsbStep = !HAS_SHIFT_ENABLE || !lsbFirstShiftEnableN;

    ////////////////////////////////////////////////////////////////////////////////
    // channel decode

    // fills the multiplexer fields from the captured assignment word
    function automatic ssadc_core_type decodeWord(
        input ssadc_core_type cur,
        input logic [`SSADC_WORD_MAX-1:0] word
    );
        ssadc_core_type res;
        int wordVal;
        int sgl;
        int odd;
        int selVal;
        int posIdx;
        int negIdx;
        res = cur;
        wordVal = int'(word);
        if (ADDR_BITS == 0)
        begin
            // single fixed differential input
            res.posSel = `SSADC_MAX_CHANNELS'(1);
            res.negSel = `SSADC_MAX_CHANNELS'(1);
            res.negCommon = 1'b0;
            res.singleEnded = 1'b0;
        end
        else
        begin
            sgl = (wordVal >> (ADDR_BITS - 1)) & 1;
            odd = (wordVal >> (ADDR_BITS - 2)) & 1;
            selVal = wordVal & ((1 << SEL_BITS) - 1);
            posIdx = selVal * 2 + odd;
            negIdx = selVal * 2 + (1 - odd);
            res.posSel = `SSADC_MAX_CHANNELS'(1) << posIdx;
            res.singleEnded = (sgl == 1);
            if (sgl == 1)
            begin
                res.negSel = '0;
                res.negCommon = 1'b1;
            end
            else
            begin
                res.negSel = `SSADC_MAX_CHANNELS'(1) << negIdx;
                res.negCommon = 1'b0;
            end
        end
        return res;
    endfunction

    // enters the settling interval with the output driving a zero
    function automatic ssadc_core_type beginSettle(
        input ssadc_core_type cur,
        input logic [`SSADC_WORD_MAX-1:0] word
    );
        ssadc_core_type res;
        res = decodeWord(cur, word);
        res.state = ST_SETTLE;
        res.settleHalf = 1'b0;
        res.active = 1'b1;
        res.doOe = 1'b1;
        res.doOut = 1'b0;
        res.code = `SSADC_CODE_CLEAR;
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb
    begin
        coreD = coreQ;
        coreD.sclkPrev = serialClk;
        coreD.samplePos = 1'b0;
        coreD.sampleNeg = 1'b0;
        coreD.compStrobe = 1'b0;
        coreD.push = 1'b0;
        if (csN)
        begin
            // everything but the serial clock edge detector cleared, output floating
            coreD = '0;
            coreD.state = ST_IDLE;
            coreD.sclkPrev = serialClk;
        end
        else
        begin
            case (coreQ.state)
                ST_IDLE:
                begin
                    // leading zeros ignored; start waits for buffer room
                    if (sclkRise && bufReady && (serialIn || ADDR_BITS == 0))
                    begin
                        if (ADDR_BITS == 0)
                            coreD = beginSettle(coreD, '0);
                        else
                        begin
                            coreD.state = ST_ADDR;
                            coreD.addrCnt = '0;
                            coreD.addr = '0;
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (sclkRise)
                    begin
                        // output still floating here, so the wire may be shared
                        coreD.addr = {coreQ.addr[`SSADC_WORD_MAX-2:0], serialIn};
                        coreD.addrCnt = coreQ.addrCnt + 3'h1;
                        if (int'(coreQ.addrCnt) == ADDR_BITS - 1)
                            coreD = beginSettle(coreD, coreD.addr);
                    end
                end
                ST_SETTLE:
                begin
                    // serialIn no longer looked at from here on
                    if (sclkFall && !coreQ.settleHalf)
                    begin
                        coreD.settleHalf = 1'b1;
                        coreD.samplePos = 1'b1;
                        coreD.code = `SSADC_TRIAL_FIRST;
                    end
                    else if (sclkRise && coreQ.settleHalf)
                    begin
                        coreD.sampleNeg = 1'b1;
                        coreD.state = ST_CONVERT;
                        coreD.bitIdx = `SSADC_MSB_INDEX;
                    end
                end
                ST_CONVERT:
                begin
                    if (sclkFall)
                    begin
                        // end of a period: latch decision and present it
                        coreD.compStrobe = 1'b1;
                        coreD.doOut = compGreater;
                        coreD.code[coreQ.bitIdx] = compGreater;
                        if (coreQ.bitIdx != 3'h0)
                        begin
                            coreD.code[coreQ.bitIdx - 3'h1] = 1'b1;
                            coreD.bitIdx = coreQ.bitIdx - 3'h1;
                        end
                        else
                        begin
                            // eighth decision: result complete
                            coreD.state = ST_FINISH;
                            coreD.outShift = coreD.code;
                            coreD.push = 1'b1;
                            coreD.pushData = coreD.code;
                            coreD.lsbCnt = '0;
                        end
                    end
                end
                ST_FINISH:
                begin
                    // half a period after the last decision
                    if (sclkRise)
                    begin
                        coreD.active = 1'b0;
                        coreD.state = LSB_COPY ? ST_LSB : ST_DONE;
                    end
                end
                ST_LSB:
                begin
                    if (sclkFall && lsbStep)
                    begin
                        if (coreQ.lsbCnt == `SSADC_LSB_LAST)
                        begin
                            coreD.state = ST_DONE;
                            coreD.doOut = 1'b0;
                        end
                        else
                        begin
                            coreD.doOut = coreQ.outShift[1];
                            coreD.outShift = coreQ.outShift >> 1;
                            coreD.lsbCnt = coreQ.lsbCnt + 3'h1;
                        end
                    end
                end
                ST_DONE:
                begin
                    if (sclkFall)
                        coreD.doOut = 1'b0;
                end
                default:
                begin
                    coreD.state = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            coreQ <= '0;
        else
            coreQ <= coreD;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result buffer

    assign resIf.valid = coreQ.push;
    assign resIf.data = coreQ.pushData;

    ssadc_buffer #(
        .WIDTH(`SSADC_RES_BITS)
    ) resultBuffer (
        .ref_clk(ref_clk),
        .rst(rst),
        .fill(resIf.sink),
        .outData(resultData),
        .outValid(resultValid),
        .outReady(resultReady)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign serialOut = coreQ.doOut;
    assign serialOutOe = coreQ.doOe;
    assign conversionActive = coreQ.active;
    assign trialCode = coreQ.code;
    assign posChannelSel = coreQ.posSel[CHANNELS-1:0];
    assign negChannelSel = coreQ.negSel[CHANNELS-1:0];
    assign negCommonSel = coreQ.negCommon;
    assign singleEndedSelect = coreQ.singleEnded;
    assign samplePosStrobe = coreQ.samplePos;
    assign sampleNegStrobe = coreQ.sampleNeg;
    assign compStrobe = coreQ.compStrobe;

endmodule

// file: ssadc_defs.svh
// constants for the serial successive-approximation converter interface
// Notes on behaviour
// - While chip select is low, sample serialIn on serial clock rising edges until the assignment word is captured.
// - First one on serialIn is the start bit; earlier zeros are ignored. While the result buffer is full, the code ignores ones as well.
// - After the start bit, capture a 2 to 4 bit channel assignment word.
// - After the assignment word is captured, wait half a clock period for multiplexer settling.
// - Raise conversionActive when the settling interval begins.
// - Ignore serialIn from conversion start until chip select goes high again.
// - serialOut leaves high impedance at settling and drives one leading zero.
// - Each comparator decision appears on serialOut at a falling edge; high means above.
// - Result bits leave serialOut most significant bit first.
// - Conversion ends after eight serial clock periods of decisions.
// - conversionActive falls half a clock period after the eighth decision period.
// - Keep all eight result bits in an output shift register.
// - Without shift enable, follow the MSB-first stream with an LSB-first copy.
// - After all data, serialOut goes low until chip select returns high.
// - Shift enable high holds the LSB; low clocks the result out LSB first.
// - The single-channel variant sends MSB first only, with no LSB-first copy.
// - All sequencer registers except the serial clock edge detector are held cleared while chip select is high; the result buffer keeps its entries.
// - serialIn and serialOut may share one wire; input sampled only while output floats.
// - Result is an unsigned code with 256 values.
// - Differential: sample positive input, then negative input half a period later.
// - Strobe the comparator at the end of each clock period to latch the decision.
// - Assignment word picks inputs, single-ended or differential, and pair polarity.
// - Differential selection only covers adjacent even/odd channel pairs.
`ifndef SSADC_DEFS_SVH
`define SSADC_DEFS_SVH

`define SSADC_RES_BITS 8
`define SSADC_MAX_CHANNELS 8
`define SSADC_WORD_MAX 4
`define SSADC_CNT_BITS 3
`define SSADC_TRIAL_FIRST 8'h80
`define SSADC_CODE_CLEAR 8'h00
`define SSADC_MSB_INDEX 3'h7
`define SSADC_LSB_LAST 3'h7
`define SSADC_BUF_DEPTH 2

`endif

// file: ssadc_pkg.sv
// types shared by the converter interface modules
`include "ssadc_defs.svh"

package ssadc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_SETTLE,
        ST_CONVERT,
        ST_FINISH,
        ST_LSB,
        ST_DONE
    } ssadc_state_type;

    typedef struct packed {
        ssadc_state_type state;
        logic sclkPrev;
        logic settleHalf;
        logic [`SSADC_WORD_MAX-1:0] addr;
        logic [`SSADC_CNT_BITS-1:0] addrCnt;
        logic active;
        logic doOut;
        logic doOe;
        logic [`SSADC_RES_BITS-1:0] code;
        logic [`SSADC_CNT_BITS-1:0] bitIdx;
        logic [`SSADC_RES_BITS-1:0] outShift;
        logic [`SSADC_CNT_BITS-1:0] lsbCnt;
        logic samplePos;
        logic sampleNeg;
        logic compStrobe;
        logic [`SSADC_MAX_CHANNELS-1:0] posSel;
        logic [`SSADC_MAX_CHANNELS-1:0] negSel;
        logic negCommon;
        logic singleEnded;
        logic push;
        logic [`SSADC_RES_BITS-1:0] pushData;
    } ssadc_core_type;

endpackage

// file: ssadc_stream_if.sv
// result word stream between the sequencer and its output buffer
`timescale 1ns/1ns

interface ssadc_stream_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;

    modport source (output data, output valid, input ready);
    modport sink (input data, input valid, output ready);
endinterface

// file: ssadc_buffer.sv
// two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ns
`include "ssadc_defs.svh"

module ssadc_buffer
    import ssadc_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // filling side
    ssadc_stream_if.sink fill,
    // draining side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);

    typedef struct packed {
        logic [WIDTH-1:0] ent0;
        logic [WIDTH-1:0] ent1;
        logic [1:0] cnt;
        logic notEmpty;
        logic notFull;
    } ssadc_buf_type;

    localparam ssadc_buf_type BUF_RESET = '{ent0: '0, ent1: '0, cnt: 2'h0,
                                            notEmpty: 1'b0, notFull: 1'b1};
    localparam logic [1:0] DEPTH = 2'(`SSADC_BUF_DEPTH);

    ssadc_buf_type bufQ;
    ssadc_buf_type bufD;
    logic doPush;
    logic doPop;

    assign doPush = fill.valid && bufQ.notFull;
    assign doPop = bufQ.notEmpty && outReady;

    always_comb
    begin
        bufD = bufQ;
        if (doPush && !doPop)
        begin
            if (bufQ.cnt == 2'h0)
                bufD.ent0 = fill.data;
            else
                bufD.ent1 = fill.data;
            bufD.cnt = bufQ.cnt + 2'h1;
        end
        else if (doPop && !doPush)
        begin
            bufD.ent0 = bufQ.ent1;
            bufD.cnt = bufQ.cnt - 2'h1;
        end
        else if (doPop && doPush)
        begin
            bufD.ent0 = fill.data;
        end
        bufD.notEmpty = (bufD.cnt != 2'h0);
        bufD.notFull = (bufD.cnt != DEPTH);
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            bufQ <= BUF_RESET;
        else
            bufQ <= bufD;
    end

    assign fill.ready = bufQ.notFull;
    assign outData = bufQ.ent0;
    assign outValid = bufQ.notEmpty;

endmodule

// file: ssadc_top_sva.sv
// assertions on the converter interface ports
`timescale 1ns/1ns
`include "ssadc_defs.svh"

module ssadc_top_sva
    import ssadc_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter bit HAS_SHIFT_ENABLE = 1'b1
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // host serial pins
    input wire logic csN,
    input wire logic serialOut,
    input wire logic serialOutOe,
    input wire logic conversionActive,
    // analog front end
    input wire logic compGreater,
    input wire logic [`SSADC_RES_BITS-1:0] trialCode,
    input wire logic [CHANNELS-1:0] posChannelSel,
    input wire logic [CHANNELS-1:0] negChannelSel,
    input wire logic negCommonSel,
    input wire logic singleEndedSelect,
    input wire logic samplePosStrobe,
    input wire logic sampleNegStrobe,
    input wire logic compStrobe,
    // result stream
    input wire logic [`SSADC_RES_BITS-1:0] resultData,
    input wire logic resultValid,
    input wire logic resultReady
);
    localparam logic [CHANNELS-1:0] EVEN_CH = CHANNELS'(8'h55);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    cs_clear_a: assert property (csN |=> !conversionActive && !serialOutOe
        && trialCode == 8'h00) else $error("state not cleared");
    oe_start_a: assert property ($rose(serialOutOe) |-> conversionActive && !serialOut)
        else $error("bad leading bit");
    active_oe_a: assert property (conversionActive |-> serialOutOe)
        else $error("active without output");
    neg_sample_a: assert property (sampleNegStrobe |-> trialCode == 8'h80)
        else $error("negative sample misplaced");
    pos_sample_a: assert property (samplePosStrobe |-> trialCode == 8'h80
        && conversionActive && !sampleNegStrobe) else $error("positive sample misplaced");
    decision_out_a: assert property (compStrobe |-> serialOut == $past(compGreater))
        else $error("decision not shown");
    decision_active_a: assert property (compStrobe |-> conversionActive)
        else $error("decision outside conversion");
    addr_frozen_a: assert property (conversionActive && $past(conversionActive)
        |-> $stable(posChannelSel) && $stable(negChannelSel)) else $error("select moved");
    pair_only_a: assert property (CHANNELS > 1 && negChannelSel != '0
        |-> ((negChannelSel & EVEN_CH) != '0
        ? posChannelSel == negChannelSel << 1 : posChannelSel == negChannelSel >> 1))
        else $error("bad pair");
    single_ended_a: assert property (singleEndedSelect |-> negChannelSel == '0 && negCommonSel)
        else $error("bad single ended select");
    buffer_hold_a: assert property (resultValid && !resultReady |=> resultValid
        && $stable(resultData)) else $error("result lost");
    cover property ($rose(conversionActive));
    cover property (compStrobe && serialOut);
    cover property (resultValid && !resultReady ##1 resultValid && resultReady);
endmodule

bind ssadc_top ssadc_top_sva #(.CHANNELS(CHANNELS), .HAS_SHIFT_ENABLE(HAS_SHIFT_ENABLE)) i_sva (
    .ref_clk(ref_clk), .rst(rst), .csN(csN), .serialOut(serialOut),
    .serialOutOe(serialOutOe), .conversionActive(conversionActive),
    .compGreater(compGreater), .trialCode(trialCode), .posChannelSel(posChannelSel),
    .negChannelSel(negChannelSel), .negCommonSel(negCommonSel),
    .singleEndedSelect(singleEndedSelect), .samplePosStrobe(samplePosStrobe),
    .sampleNegStrobe(sampleNegStrobe),
    .compStrobe(compStrobe), .resultData(resultData), .resultValid(resultValid),
    .resultReady(resultReady)
);

// file: ssadc_host.sv
// host and comparator model on the far side of the serial pins
`timescale 1ns/1ns

module ssadc_host
(
    // clock
    input wire logic ref_clk,
    // serial pins
    output logic csN,
    output logic serialClk,
    output logic serialIn,
    output logic lsbFirstShiftEnableN,
    input wire logic serialOut,
    // analog side
    input wire logic [7:0] trialCode,
    output logic compGreater
);
    logic [7:0] level;
    initial
    begin
        csN = 1'b1;
        serialClk = 1'b0;
        serialIn = 1'b0;
        lsbFirstShiftEnableN = 1'b1;
        level = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    // input sits half a step above level
    assign compGreater = level >= trialCode;
    ////////////////////////////////////////////////////////////////
    // chip select held low over a whole sequence
    task automatic cs(input logic v);
        @(negedge ref_clk);
        csN = v;
    endtask
    task automatic se(input logic v);
        lsbFirstShiftEnableN = v;
    endtask
    // one serial clock period: low half, sample, high half
    task automatic tick(input logic din, output logic dout);
        @(negedge ref_clk);
        serialIn = din;
        repeat (4) @(negedge ref_clk);
        dout = serialOut;
        serialClk = 1'b1;
        repeat (4) @(negedge ref_clk);
        serialClk = 1'b0;
    endtask
endmodule

// file: ssadc_top_test.sv
// self-checking bench for the converter interface
`timescale 1ns/1ns

module ssadc_top_test
    import ssadc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic csN, serialClk, serialIn, seN, serialOut, serialOutOe, active, compGreater;
    logic [7:0] trialCode, resultData, posSel, negSel;
    logic negCommon, singleEnded, posStrobe, negStrobe, compStrobe, resultValid;
    logic resultReady = 1'b1;
    int bad_count = 0;
    int n_checks = 0;
    int cycles = 0;
    always #2 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////
    ssadc_top i_dut (
        .ref_clk(ref_clk), .rst(rst), .csN(csN), .serialClk(serialClk),
        .serialIn(serialIn), .lsbFirstShiftEnableN(seN), .serialOut(serialOut),
        .serialOutOe(serialOutOe), .conversionActive(active), .compGreater(compGreater),
        .trialCode(trialCode), .posChannelSel(posSel), .negChannelSel(negSel),
        .negCommonSel(negCommon), .singleEndedSelect(singleEnded),
        .samplePosStrobe(posStrobe), .sampleNegStrobe(negStrobe), .compStrobe(compStrobe),
        .resultData(resultData), .resultValid(resultValid), .resultReady(resultReady)
    );
    ssadc_host i_host (
        .ref_clk(ref_clk), .csN(csN), .serialClk(serialClk), .serialIn(serialIn),
        .lsbFirstShiftEnableN(seN), .serialOut(serialOut), .trialCode(trialCode),
        .compGreater(compGreater)
    );
    ////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            bad_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////
    // leading zero, start bit, four word bits
    task automatic addr(input logic [3:0] w);
        logic d;
        i_host.cs(1'b0);
        i_host.tick(1'b0, d);
        i_host.tick(1'b1, d);
        for (int i = 3; i >= 0; i--)
        begin
            check("oe", 8'(serialOutOe), 8'h00);
            i_host.tick(w[i], d);
        end
    endtask
    task automatic cleared();
        repeat (2) @(negedge ref_clk);
        check("clear", trialCode | posSel | {serialOutOe, active, 6'h00}, 8'h00);
    endtask
    task automatic conv(input logic [3:0] w, input logic [7:0] lv, input int hold);
        logic d;
        logic [7:0] got;
        i_host.level = lv;
        i_host.se(1'(hold != 0));
        addr(w);
        check("pos", posSel, 8'h01 << {w[1:0], w[2]});
        check("neg", negSel, w[3] ? 8'h00 : 8'h01 << {w[1:0], ~w[2]});
        check("common", 8'(negCommon), 8'(w[3]));
        i_host.tick(1'b1, d);
        check("lead", {5'h00, serialOutOe, active, d}, 8'h06);
        for (int i = 0; i < 8; i++)
        begin
            i_host.tick(1'(i), d);
            got = {got[6:0], d};
            check("active", 8'(active), 8'(i < 7));
        end
        check("msb", got, lv);
        for (int i = 0; i < hold; i++)
        begin
            i_host.tick(1'b0, d);
            check("hold", 8'(d), 8'(lv[0]));
        end
        i_host.se(1'b0);
        for (int i = 1; i < 8; i++)
        begin
            i_host.tick(1'b0, d);
            got[i] = d;
        end
        check("lsb", got & 8'hfe, lv & 8'hfe);
        repeat (2)
        begin
            i_host.tick(1'b0, d);
            check("tail", 8'(d), 8'h00);
        end
        i_host.cs(1'b1);
        cleared();
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic buffer_full();
        logic d;
        resultReady = 1'b0;
        conv(4'b1000, 8'h81, 0);
        conv(4'b1100, 8'h7e, 0);
        addr(4'b1000);
        i_host.tick(1'b0, d);
        check("refused", 8'(serialOutOe), 8'h00);
        i_host.cs(1'b1);
        check("head", resultData, 8'h81);
        resultReady = 1'b1;
        @(negedge ref_clk);
        check("next", resultData, 8'h7e);
        @(negedge ref_clk);
        check("empty", 8'(resultValid), 8'h00);
    endtask
    task automatic abort_mid();
        logic d;
        addr(4'b1010);
        repeat (3) i_host.tick(1'b1, d);
        i_host.cs(1'b1);
        cleared();
        conv(4'b1010, 8'h5a, 0);
    endtask
    initial
    begin
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        conv(4'b1001, 8'ha5, 0);
        conv(4'b0110, 8'h3c, 2);
        conv(4'b1111, 8'hff, 0);
        conv(4'b0000, 8'h00, 1);
        buffer_full();
        abort_mid();
        finish_test();
    end
endmodule
